// *** fdv_cal_model.sv ***
module fdv_cal_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cal_start,
    input  wire logic [7:0] delay_cycles,
    input  wire logic [3:0] code,
    output logic            cal_done_in,
    output logic      [3:0] cal_code_in
);
    typedef struct packed {
        logic       run;
        logic [7:0] cnt;
    } fdv_cal_model_t;
    fdv_cal_model_t st_q;
    fdv_cal_model_t st_d;
    always_comb begin
        st_d = st_q;
        if (st_q.run) begin
            if (st_q.cnt == 8'h00) st_d.run = 1'h0;
            else st_d.cnt = st_q.cnt - 8'h01;
        end
        // a restart throws away the conversion in flight
        if (cal_start) begin
            st_d.run = 1'h1;
            st_d.cnt = delay_cycles;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) st_q <= '0;
        else st_q <= st_d;
    end
    assign cal_done_in = st_q.run && (st_q.cnt == 8'h00);
    // code only means something beside the done pulse, so it is scrambled otherwise
    assign cal_code_in = cal_done_in ? code : ~code;
endmodule

// *** fdv_pkg.sv ***
package fdv_pkg;
    // register map
    localparam logic [7:0] ADDR_CAL_GPIO = 8'h05;
    localparam logic [7:0] ADDR_VOUT     = 8'h06;
    localparam logic [7:0] RST_CAL_GPIO  = 8'h6a;
    localparam logic [7:0] RST_VOUT      = 8'h09;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // calibration / gpio / led enable fields
    localparam int CAL_BIT   = 7;
    localparam int PSM_BIT   = 6;
    localparam int DIR_BIT   = 5;
    localparam int GPIO_BIT  = 4;
    localparam int TYPE_BIT  = 3;
    localparam int LED_MSB   = 2;
    localparam int LED_LSB   = 0;

    // output voltage fields
    localparam int THERM_BIT = 7;
    localparam int HOT_BIT   = 6;
    localparam int WARN_BIT  = 5;
    localparam int HDR_BIT   = 4;
    localparam int CODE_MSB  = 3;
    localparam int CODE_LSB  = 0;

    // boost target: base + code * step, in millivolts
    localparam logic [15:0] VOUT_BASE_MV = 16'h0ef1;
    localparam logic [15:0] VOUT_STEP_MV = 16'h007d;
    localparam logic [15:0] VOUT_TOP_MV  = 16'h1644;

    // thermistor comparator trip points, millivolts, applied in the analog front end
    localparam logic [15:0] TS_HOT_MV    = 16'h0159;
    localparam logic [15:0] TS_WARN_MV   = 16'h041a;

    typedef enum logic {
        FDV_CAL_IDLE,
        FDV_CAL_RUN
    } fdv_cal_state_t;
endpackage

// *** fdv_regs.sv ***
// Operation
// - writing one to bit 7 of register 5 starts self-calibration; zero stops it
// - bit 7 reads zero while calibration runs and one when it is done
// - done status stays set until the next calibration start clears it
// - bit 6 enables power-save mode; resets to one
// - bit 5 reads the dc-light enable pin level on that variant
// - writing bit 5 sets gpio direction: zero input, one output
// - bit 4 holds the gpio port value, seen or driven
// - bit 3 selects gpio push-pull (zero) or open-drain (one); resets one
// - bits 2..0 enable led channels 3, 2 and 1
// - headroom bit latches at each flash strobe end, before ramp-down
// - voltage field reads the latest calibration result code
// - voltage field write sets boost target, 3.825 V to 5.700 V linear
// - thermal variant: bit 7 of register 6 enables temperature monitoring
// - hot flag sets below 0.345 V, held until host writes zero
// - warning flag sets below 1.05 V and clears on read
// - hot flag forces shutdown, latched until the flag is cleared
// - gpio drives power-good when route bit is zero, else port value
module fdv_regs #(
    parameter int unsigned HAS_THERMAL = 0,
    parameter int unsigned HAS_DCL_PIN = 1
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       dc_light_enable_pin,
    input  wire logic       gpio_pin_in,
    output logic            gpio_pin_out,
    output logic            gpio_pin_oe,
    input  wire logic       power_good,
    input  wire logic       power_good_route,
    input  wire logic       cal_done_in,
    input  wire logic [3:0] cal_code_in,
    input  wire logic       strobe_end,
    input  wire logic       headroom_in,
    input  wire logic       ts_below_warn,
    input  wire logic       ts_below_hot,
    output logic            forward_voltage_calibrate,
    output logic            cal_start,
    output logic            power_save_enable,
    output logic      [2:0] led_channel_enable,
    output logic      [3:0] target_voltage_code,
    output logic            thermal_monitor_enable,
    output logic            thermal_shutdown
);
    if (HAS_THERMAL > 1 || HAS_DCL_PIN > 1) begin : g_param_check
        $error("variant parameters must be 0 or 1");
    end

    typedef struct packed {
        logic                    cal_en;
        logic                    cal_start;
        fdv_pkg::fdv_cal_state_t cal_state;
        logic                    cal_done;
        logic                    psm;
        logic                    dir;
        logic                    port;
        logic                    otype;
        logic [2:0]              led;
        logic                    hdr;
        logic [3:0]              target;
        logic [3:0]              cal_code;
        logic                    therm_en;
        logic [7:0]              rdata;
        logic                    gpio_out;
        logic                    gpio_oe;
    } fdv_state_t;

    fdv_state_t s_q;
    fdv_state_t s_d;

    logic       wr_cal;
    logic       wr_vout;
    logic       rd_vout;
    logic       warn_flag;
    logic       hot_flag;
    logic       shutdown;
    logic       gpio_level;
    logic [7:0] rd_cal_gpio;
    logic [7:0] rd_vout_val;

    assign wr_cal  = reg_wr && (reg_addr == fdv_pkg::ADDR_CAL_GPIO);
    assign wr_vout = reg_wr && (reg_addr == fdv_pkg::ADDR_VOUT);
    assign rd_vout = reg_rd && (reg_addr == fdv_pkg::ADDR_VOUT);

    fdv_thermal u_thermal (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .monitor_enable (s_q.therm_en),
        .ts_below_warn  (ts_below_warn),
        .ts_below_hot   (ts_below_hot),
        .hot_clear      (wr_vout && !reg_wdata[fdv_pkg::HOT_BIT] && HAS_THERMAL == 1),
        .warn_read      (rd_vout && HAS_THERMAL == 1),
        .warn_flag      (warn_flag),
        .hot_flag       (hot_flag),
        .shutdown       (shutdown)
    );

    // an input pin reads its own level; an output reads back the stored port value
    assign gpio_level = s_q.dir ? s_q.port : gpio_pin_in;

    always_comb begin
        rd_cal_gpio = '0;
        rd_cal_gpio[fdv_pkg::CAL_BIT]  = s_q.cal_done;
        rd_cal_gpio[fdv_pkg::PSM_BIT]  = s_q.psm;
        rd_cal_gpio[fdv_pkg::DIR_BIT]  = (HAS_DCL_PIN == 1) ? dc_light_enable_pin : s_q.dir;
        rd_cal_gpio[fdv_pkg::GPIO_BIT] = gpio_level;
        rd_cal_gpio[fdv_pkg::TYPE_BIT] = s_q.otype;
        rd_cal_gpio[fdv_pkg::LED_MSB:fdv_pkg::LED_LSB] = s_q.led;
        rd_vout_val = '0;
        rd_vout_val[fdv_pkg::HDR_BIT] = s_q.hdr;
        rd_vout_val[fdv_pkg::CODE_MSB:fdv_pkg::CODE_LSB] = s_q.cal_code;
        if (HAS_THERMAL == 1) begin
            rd_vout_val[fdv_pkg::THERM_BIT] = s_q.therm_en;
            rd_vout_val[fdv_pkg::HOT_BIT]   = hot_flag;
            rd_vout_val[fdv_pkg::WARN_BIT]  = warn_flag;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.cal_start = 1'b0;

        if (wr_cal) begin
            s_d.cal_en = reg_wdata[fdv_pkg::CAL_BIT];
            s_d.psm    = reg_wdata[fdv_pkg::PSM_BIT];
            s_d.dir    = reg_wdata[fdv_pkg::DIR_BIT];
            s_d.port   = reg_wdata[fdv_pkg::GPIO_BIT];
            s_d.otype  = reg_wdata[fdv_pkg::TYPE_BIT];
            s_d.led    = reg_wdata[fdv_pkg::LED_MSB:fdv_pkg::LED_LSB];
            if (reg_wdata[fdv_pkg::CAL_BIT]) begin
                // every write of one restarts, even when already enabled
                s_d.cal_start = 1'b1;
                s_d.cal_state = fdv_pkg::FDV_CAL_RUN;
                s_d.cal_done  = 1'b0;
            end else begin
                s_d.cal_state = fdv_pkg::FDV_CAL_IDLE;
            end
        end

        // a finishing calibration beats a same-cycle restart so its result is not lost
        case (s_q.cal_state)
            fdv_pkg::FDV_CAL_IDLE: begin
            end
            fdv_pkg::FDV_CAL_RUN: begin
                if (cal_done_in) begin
                    s_d.cal_done  = 1'b1;
                    s_d.cal_code  = cal_code_in;
                    s_d.cal_state = fdv_pkg::FDV_CAL_IDLE;
                end
            end
            default: begin
                s_d.cal_state = fdv_pkg::FDV_CAL_IDLE;
            end
        endcase

        if (wr_vout) begin
            // code maps to base + code * step millivolts in the analog loop
            s_d.target = reg_wdata[fdv_pkg::CODE_MSB:fdv_pkg::CODE_LSB];
            if (HAS_THERMAL == 1) begin
                s_d.therm_en = reg_wdata[fdv_pkg::THERM_BIT];
            end
        end

        if (strobe_end) begin
            s_d.hdr = headroom_in;
        end

        if (reg_rd) begin
            if (reg_addr == fdv_pkg::ADDR_CAL_GPIO) begin
                s_d.rdata = rd_cal_gpio;
            end else if (reg_addr == fdv_pkg::ADDR_VOUT) begin
                s_d.rdata = rd_vout_val;
            end else begin
                s_d.rdata = fdv_pkg::READ_UNMAPPED;
            end
        end

        // pin driver follows the stored setting one cycle later
        s_d.gpio_out = power_good_route ? s_q.port : power_good;
        s_d.gpio_oe  = s_q.dir;
        if (s_q.otype) begin
            s_d.gpio_oe  = s_q.dir && !s_d.gpio_out;
            s_d.gpio_out = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q           <= '0;
            s_q.cal_state <= fdv_pkg::FDV_CAL_IDLE;
            s_q.cal_en    <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::CAL_BIT];
            s_q.psm       <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::PSM_BIT];
            s_q.dir       <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::DIR_BIT];
            s_q.port      <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::GPIO_BIT];
            s_q.otype     <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::TYPE_BIT];
            s_q.led       <= fdv_pkg::RST_CAL_GPIO[fdv_pkg::LED_MSB:fdv_pkg::LED_LSB];
            s_q.target    <= fdv_pkg::RST_VOUT[fdv_pkg::CODE_MSB:fdv_pkg::CODE_LSB];
            s_q.cal_code  <= fdv_pkg::RST_VOUT[fdv_pkg::CODE_MSB:fdv_pkg::CODE_LSB];
        end else begin
            s_q <= s_d;
        end
    end

    // thermal outputs must also come from flops of this module
    logic shutdown_q;
    logic therm_en_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shutdown_q <= 1'b0;
            therm_en_q <= 1'b0;
        end else begin
            shutdown_q <= shutdown;
            therm_en_q <= s_d.therm_en;
        end
    end

    assign reg_rdata                 = s_q.rdata;
    assign gpio_pin_out              = s_q.gpio_out;
    assign gpio_pin_oe               = s_q.gpio_oe;
    assign forward_voltage_calibrate = s_q.cal_en;
    assign cal_start                 = s_q.cal_start;
    assign power_save_enable         = s_q.psm;
    assign led_channel_enable        = s_q.led;
    assign target_voltage_code       = s_q.target;
    assign thermal_monitor_enable    = therm_en_q;
    assign thermal_shutdown          = shutdown_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_cal_start;
        wr_cal && reg_wdata[fdv_pkg::CAL_BIT] && !(s_q.cal_state == fdv_pkg::FDV_CAL_RUN && cal_done_in)
            |=> cal_start && forward_voltage_calibrate && !s_q.cal_done;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration start not seen");

    property p_cal_done_holds;
        s_q.cal_done && !(wr_cal && reg_wdata[fdv_pkg::CAL_BIT]) |=> s_q.cal_done;
    endproperty
    a_cal_done_holds: assert property (p_cal_done_holds) else $error("done cleared without restart");

    property p_cal_result;
        s_q.cal_state == fdv_pkg::FDV_CAL_RUN && cal_done_in
            |=> s_q.cal_done && s_q.cal_code == $past(cal_code_in)
            ##1 (reg_rd && reg_addr == fdv_pkg::ADDR_VOUT ? 1'b1 : 1'b1);
    endproperty
    a_cal_result: assert property (p_cal_result) else $error("calibration result not stored");

    property p_cal_read;
        reg_rd && reg_addr == fdv_pkg::ADDR_CAL_GPIO
            |=> reg_rdata[fdv_pkg::CAL_BIT] == $past(s_q.cal_done)
            && reg_rdata[fdv_pkg::DIR_BIT] == $past(HAS_DCL_PIN == 1 ? dc_light_enable_pin : s_q.dir);
    endproperty
    a_cal_read: assert property (p_cal_read) else $error("register 5 read mismatch");

    property p_reg5_write;
        wr_cal |=> power_save_enable == $past(reg_wdata[fdv_pkg::PSM_BIT])
            && led_channel_enable == $past(reg_wdata[fdv_pkg::LED_MSB:fdv_pkg::LED_LSB])
            && s_q.otype == $past(reg_wdata[fdv_pkg::TYPE_BIT]);
    endproperty
    a_reg5_write: assert property (p_reg5_write) else $error("register 5 fields not written");

    property p_target_write;
        wr_vout |=> target_voltage_code == $past(reg_wdata[fdv_pkg::CODE_MSB:fdv_pkg::CODE_LSB])
            && thermal_monitor_enable
            == (HAS_THERMAL == 1 ? $past(reg_wdata[fdv_pkg::THERM_BIT]) : 1'b0);
    endproperty
    a_target_write: assert property (p_target_write) else $error("target code not written");

    property p_headroom;
        strobe_end |=> s_q.hdr == $past(headroom_in);
    endproperty
    a_headroom: assert property (p_headroom) else $error("headroom not latched");

    property p_gpio_pg_route;
        !power_good_route && !s_q.otype |=> gpio_pin_out == $past(power_good);
    endproperty
    a_gpio_pg_route: assert property (p_gpio_pg_route) else $error("gpio not carrying power good");

    property p_gpio_opendrain;
        s_q.otype |=> !gpio_pin_out;
    endproperty
    a_gpio_opendrain: assert property (p_gpio_opendrain) else $error("open drain drove high");

    property p_gpio_input;
        !s_q.dir |=> !gpio_pin_oe;
    endproperty
    a_gpio_input: assert property (p_gpio_input) else $error("input pin is driven");

    property p_shutdown;
        hot_flag |=> thermal_shutdown;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("hot flag without shutdown");

    c_cal_cycle: cover property (cal_start ##[1:50] s_q.cal_done);
    c_strobe: cover property (strobe_end && headroom_in);
    c_warn_read: cover property (warn_flag && rd_vout);
endmodule

// *** fdv_thermal.sv ***
module fdv_thermal (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic monitor_enable,
    input  wire logic ts_below_warn,
    input  wire logic ts_below_hot,
    input  wire logic hot_clear,
    input  wire logic warn_read,
    output logic      warn_flag,
    output logic      hot_flag,
    output logic      shutdown
);
    typedef struct packed {
        logic warn;
        logic hot;
        logic shut;
    } fdv_therm_state_t;

    fdv_therm_state_t s_q;
    fdv_therm_state_t s_d;

    logic warn_evt;
    logic hot_evt;

    assign warn_evt = monitor_enable && ts_below_warn;
    assign hot_evt  = monitor_enable && ts_below_hot;

    always_comb begin
        s_d = s_q;
        // the read data already holds the old value, so a fresh event must survive the clear
        s_d.warn = warn_evt || (s_q.warn && !warn_read);
        s_d.hot  = hot_evt || (s_q.hot && !hot_clear);
        s_d.shut = s_d.hot;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign warn_flag = s_q.warn;
    assign hot_flag  = s_q.hot;
    assign shutdown  = s_q.shut;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_hot_sets_and_shuts;
        hot_evt |=> hot_flag && shutdown;
    endproperty
    a_hot_sets_and_shuts: assert property (p_hot_sets_and_shuts) else $error("hot not latched");

    property p_hot_holds;
        hot_flag && !hot_clear |=> hot_flag && shutdown;
    endproperty
    a_hot_holds: assert property (p_hot_holds) else $error("hot dropped without clear");

    property p_warn_read_clears;
        warn_flag && warn_read && !warn_evt |=> !warn_flag;
    endproperty
    a_warn_read_clears: assert property (p_warn_read_clears) else $error("warn kept after read");

    property p_warn_not_lost;
        warn_read && warn_evt |=> warn_flag;
    endproperty
    a_warn_not_lost: assert property (p_warn_not_lost) else $error("warn lost during read");

    c_hot_then_clear: cover property (hot_flag ##[1:20] !hot_flag);
endmodule

// *** flash_driver_gpio_voltage_regs_bench.sv ***
module flash_driver_gpio_voltage_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk, reset, reg_wr, reg_rd, dcl, gpio_in, pg, route;
    logic       strobe_end, headroom_in, ts_warn, ts_hot, cal_done_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cal_delay, rd, m5, m6, d;
    logic [3:0] cal_code_in, code, cal_code, target;
    logic       cal_done, hdr, pin_out, pin_oe, fvc, cal_start, psm, tme, tsd;
    logic [2:0] led;
    integer     seed, error_cnt, comparisons, cycles, i;

    fdv_regs #(.HAS_THERMAL(1), .HAS_DCL_PIN(1)) dut_u (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dc_light_enable_pin(dcl), .gpio_pin_in(gpio_in), .gpio_pin_out(pin_out),
        .gpio_pin_oe(pin_oe), .power_good(pg), .power_good_route(route),
        .cal_done_in(cal_done_in), .cal_code_in(cal_code_in), .strobe_end(strobe_end),
        .headroom_in(headroom_in), .ts_below_warn(ts_warn), .ts_below_hot(ts_hot),
        .forward_voltage_calibrate(fvc), .cal_start(cal_start), .power_save_enable(psm),
        .led_channel_enable(led), .target_voltage_code(target),
        .thermal_monitor_enable(tme), .thermal_shutdown(tsd));
    fdv_cal_model cal_u (
        .ref_clk(ref_clk), .reset(reset), .cal_start(cal_start), .delay_cycles(cal_delay),
        .code(code), .cal_done_in(cal_done_in), .cal_code_in(cal_code_in));

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        // whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            $display("unexpected timeout expected end seen hang");
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            error_cnt = error_cnt + 1;
        end
    endtask
    task automatic strobe(input logic h);
        @(posedge ref_clk);
        strobe_end <= 1'h1;
        headroom_in <= h;
        @(posedge ref_clk);
        strobe_end <= 1'h0;
        headroom_in <= ~h;
        hdr = h;
    endtask

    function automatic logic [7:0] exp5();
        return {cal_done, m5[6], dcl, m5[5] ? m5[4] : gpio_in, m5[3], m5[2:0]};
    endfunction
    function automatic logic [7:0] exp6(input logic h, input logic w);
        return {m6[7], h, w, hdr, cal_code};
    endfunction
    function automatic logic [7:0] gpio_exp();
        logic v;
        v = route ? m5[4] : pg;
        return m5[3] ? {6'h00, m5[5] & ~v, 1'h0} : {6'h00, m5[5], v};
    endfunction

    initial begin
        seed = 31579;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        reset = 1'h1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {dcl, gpio_in, pg, route} = 4'h9;
        {strobe_end, headroom_in, ts_warn, ts_hot} = 4'h0;
        cal_delay = 8'h01;
        code = 4'h5;
        m5 = 8'h6a;
        m6 = 8'h09;
        {cal_done, hdr, cal_code} = 6'h09;
        repeat (3) @(posedge ref_clk);
        reset <= 1'h0;

        rdr(8'h05);
        chk("reg5 reset", 8'h6a, rd);
        rdr(8'h06);
        chk("reg6 reset", 8'h09, rd);
        chk("outputs reset", 8'ha9, {psm, led, target});
        chk("gpio reset", gpio_exp(), {6'h00, pin_oe, pin_out});
        rdr(8'h33);
        chk("unmapped read", 8'h00, rd);
        wr(8'h33, 8'hff);
        rdr(8'h05);
        chk("reg5 after stray write", exp5(), rd);
        $display("test reset done");

        for (i = 0; i < 16; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed)) & 8'h7f;
            @(posedge ref_clk);
            {dcl, gpio_in, pg, route} <= 4'($random(seed));
            wr(8'h05, d);
            m5 = d;
            tick(2);
            chk("gpio pins", gpio_exp(), {6'h00, pin_oe, pin_out});
            chk("reg5 outputs", {1'h0, d[6], 3'h0, d[2:0]}, {fvc, psm, 3'h0, led});
            rdr(8'h05);
            chk("reg5 read", exp5(), rd);
        end
        $display("test gpio done");

        // prompt and slow answers from the calibration engine
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            cal_delay <= (i == 0) ? 8'h01 : 8'h1e;
            code <= 4'($random(seed));
            wr(8'h05, 8'hc2);
            m5 = 8'hc2;
            cal_done = 1'h0;
            #1;
            chk("cal start", 8'h03, {6'h00, cal_start, fvc});
            rdr(8'h05);
            chk("cal running", exp5(), rd);
            tick(40);
            cal_done = 1'h1;
            cal_code = code;
            rdr(8'h05);
            chk("cal done", exp5(), rd);
            rdr(8'h06);
            chk("cal code", exp6(1'h0, 1'h0), rd);
            wr(8'h05, 8'h42);
            m5 = 8'h42;
            rdr(8'h05);
            chk("done held", exp5(), rd);
        end
        // abort mid-run: the late done pulse must be ignored
        wr(8'h05, 8'hc2);
        wr(8'h05, 8'h42);
        cal_done = 1'h0;
        tick(40);
        rdr(8'h05);
        chk("cal aborted", exp5(), rd);
        $display("test calibration done");

        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hbf : 8'($random(seed)) & 8'hbf;
            wr(8'h06, d);
            m6 = d;
            tick(1);
            chk("target", {d[7], 3'h0, d[3:0]}, {tme, 3'h0, target});
            rdr(8'h06);
            chk("reg6 read", exp6(1'h0, 1'h0), rd);
        end
        for (i = 0; i < 2; i++) begin
            strobe(i == 0);
            tick(2);
            rdr(8'h06);
            chk("headroom", exp6(1'h0, 1'h0), rd);
        end
        $display("test voltage done");

        wr(8'h06, 8'h80);
        m6 = 8'h80;
        @(posedge ref_clk);
        ts_warn <= 1'h1;
        @(posedge ref_clk);
        ts_warn <= 1'h0;
        rdr(8'h06);
        chk("warn set", exp6(1'h0, 1'h1), rd);
        rdr(8'h06);
        chk("warn cleared", exp6(1'h0, 1'h0), rd);
        // the event stands on the edge before the read and on the read edge, so only the kept event can hold the flag after it
        @(posedge ref_clk);
        ts_warn <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= 8'h06;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        ts_warn <= 1'h0;
        #1;
        rd = reg_rdata;
        chk("warn during read", exp6(1'h0, 1'h1), rd);
        rdr(8'h06);
        chk("warn kept", exp6(1'h0, 1'h1), rd);
        rdr(8'h06);
        chk("warn gone", exp6(1'h0, 1'h0), rd);
        @(posedge ref_clk);
        ts_hot <= 1'h1;
        @(posedge ref_clk);
        ts_hot <= 1'h0;
        tick(2);
        chk("shutdown", 8'h01, {7'h00, tsd});
        rdr(8'h06);
        chk("hot set", exp6(1'h1, 1'h0), rd);
        wr(8'h06, 8'hc0);
        tick(2);
        chk("shutdown held", 8'h01, {7'h00, tsd});
        wr(8'h06, 8'h80);
        tick(2);
        chk("shutdown cleared", 8'h00, {7'h00, tsd});
        rdr(8'h06);
        chk("hot cleared", exp6(1'h0, 1'h0), rd);
        wr(8'h06, 8'h00);
        m6 = 8'h00;
        @(posedge ref_clk);
        {ts_hot, ts_warn} <= 2'h3;
        @(posedge ref_clk);
        {ts_hot, ts_warn} <= 2'h0;
        tick(2);
        chk("monitor off", 8'h00, {7'h00, tsd});
        rdr(8'h06);
        chk("monitor off flags", exp6(1'h0, 1'h0), rd);
        $display("test thermal done");
        finish_test();
    end
endmodule
